// ### hdl/lmb_cfg.svh
`ifndef LMB_CFG_SVH
`define LMB_CFG_SVH

// message store geometry
`define LMB_DEPTH 96
`define LMB_PTR_W 7

// register byte addresses on the apb bus
`define LMB_OFS_PORT 12'h700
`define LMB_OFS_CTRL 12'h704
`define LMB_OFS_STAT 12'h708
`define LMB_OFS_ISTAT 12'h70C
`define LMB_OFS_IMASK 12'h710

// control register fields, write-one pulses
`define LMB_CTRL_RESTART 0
`define LMB_CTRL_SEND 1

// status register fields
`define LMB_STAT_TXFREE 0
`define LMB_STAT_RXPTR 1
`define LMB_STAT_PTR_LSB 8
`define LMB_STAT_LEN_LSB 16

// interrupt status and mask fields
`define LMB_IRQ_TXDONE 0
`define LMB_IRQ_RX_END_OF_TRANSFER_IRQ 1
`define LMB_IRQ_OVF 2
`define LMB_IRQ_W 3

// reset values
`define LMB_RST_PORT 8'h00
`define LMB_RST_IMASK 3'h0

`endif

// ### hdl/lmb_pkg.sv
package lmb_pkg;

    // buffer ownership states
    typedef enum logic [1:0] {
        LMB_IDLE = 2'b00,
        LMB_TX_SEND = 2'b01,
        LMB_RX_FILL = 2'b10
    } lmb_state_t;

    // register decode result
    typedef enum logic [2:0] {
        LMB_SEL_NONE = 3'b000,
        LMB_SEL_PORT = 3'b001,
        LMB_SEL_CTRL = 3'b010,
        LMB_SEL_STAT = 3'b011,
        LMB_SEL_ISTAT = 3'b100,
        LMB_SEL_IMASK = 3'b101
    } lmb_sel_t;

    // one message byte on the frame side
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } lmb_byte_t;

endpackage : lmb_pkg

// ### hdl/lmb_store.sv
`timescale 1ns/1ns
`default_nettype none
`include "lmb_cfg.svh"

module lmb_store
    import lmb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [`LMB_PTR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [`LMB_PTR_W-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [`LMB_PTR_W-1:0] raddr_b,
    output logic [7:0] rdata_b
);

    logic [7:0] mem_ff [`LMB_DEPTH];
    logic [7:0] nxt_mem [`LMB_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // one byte cell per entry, written when addressed
    genvar gi;
    generate
        for (gi = 0; gi < `LMB_DEPTH; gi++) begin : g_cell
            always_comb begin
                nxt_mem[gi] = mem_ff[gi];
                if (we && (waddr == `LMB_PTR_W'(gi))) begin
                    nxt_mem[gi] = wdata;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem_ff[gi] <= `LMB_RST_PORT;
                end else begin
                    mem_ff[gi] <= nxt_mem[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // two read ports, out of range reads give zero
    assign rdata_a = (raddr_a < `LMB_PTR_W'(`LMB_DEPTH)) ? mem_ff[raddr_a] : 8'h00;
    assign rdata_b = (raddr_b < `LMB_PTR_W'(`LMB_DEPTH)) ? mem_ff[raddr_b] : 8'h00;

endmodule : lmb_store

`default_nettype wire

// ### hdl/lmb_msg_buffer.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lmb_cfg.svh"

module lmb_msg_buffer
    import lmb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire lmb_byte_t rx_in,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic tx_buffer_free_flag,
    output logic rx_buffer_pointer_flag,
    output logic rx_end_of_transfer_irq,
    output logic irq
);

    localparam logic [`LMB_PTR_W-1:0] DEPTH = `LMB_PTR_W'(`LMB_DEPTH);

    lmb_state_t state_ff, nxt_state;
    logic [`LMB_PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [`LMB_PTR_W-1:0] len_ff, nxt_len;
    logic [`LMB_PTR_W-1:0] tx_idx_ff, nxt_tx_idx;
    logic holds_tx_ff, nxt_holds_tx;
    logic pending_ff, nxt_pending;
    logic [`LMB_IRQ_W-1:0] istat_ff, nxt_istat;
    logic [`LMB_IRQ_W-1:0] imask_ff, nxt_imask;
    logic mem_we;
    logic [`LMB_PTR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] port_byte;
    logic [7:0] tx_byte;
    logic ev_txdone, ev_rx_end_of_transfer_irq, ev_ovf;
    logic acc, wr, rd, port_wr, port_rd, ctl_wr;
    lmb_sel_t sel;

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by the write and read paths
    function automatic lmb_sel_t decode(input logic [11:0] a);
        case (a)
            `LMB_OFS_PORT: decode = LMB_SEL_PORT;
            `LMB_OFS_CTRL: decode = LMB_SEL_CTRL;
            `LMB_OFS_STAT: decode = LMB_SEL_STAT;
            `LMB_OFS_ISTAT: decode = LMB_SEL_ISTAT;
            `LMB_OFS_IMASK: decode = LMB_SEL_IMASK;
            default: decode = LMB_SEL_NONE;
        endcase
    endfunction : decode

    // access phase strobes, zero wait states
    assign sel = decode(paddr);
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign port_wr = wr && (sel == LMB_SEL_PORT);
    assign port_rd = rd && (sel == LMB_SEL_PORT);
    assign ctl_wr = wr && (sel == LMB_SEL_CTRL);
    assign pready = 1'b1;
    assign pslverr = acc && (sel == LMB_SEL_NONE);

    ////////////////////////////////////////////////////////////////////////
    // byte store
    lmb_store u_store (
        .clk(clk),
        .rst(rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(ptr_ff),
        .rdata_a(port_byte),
        .raddr_b(tx_idx_ff),
        .rdata_b(tx_byte)
    );

    ////////////////////////////////////////////////////////////////////////
    // frame side handshakes and flags
    assign tx_valid = (state_ff == LMB_TX_SEND);
    assign tx_data = tx_byte;
    assign tx_last = tx_valid && (tx_idx_ff == len_ff - `LMB_PTR_W'(1));
    assign rx_ready = (state_ff == LMB_RX_FILL) || ((state_ff == LMB_IDLE) && !pending_ff && !holds_tx_ff);
    assign tx_buffer_free_flag = (state_ff == LMB_IDLE) && !pending_ff;
    assign rx_buffer_pointer_flag = pending_ff;
    assign rx_end_of_transfer_irq = istat_ff[`LMB_IRQ_RX_END_OF_TRANSFER_IRQ];
    assign irq = |(istat_ff & imask_ff);

    ////////////////////////////////////////////////////////////////////////
    // buffer ownership, pointer and length
    always_comb begin
        nxt_state = state_ff;
        nxt_ptr = ptr_ff;
        nxt_len = len_ff;
        nxt_tx_idx = tx_idx_ff;
        nxt_holds_tx = holds_tx_ff;
        nxt_pending = pending_ff;
        mem_we = 1'b0;
        mem_waddr = ptr_ff;
        mem_wdata = rx_in.data;
        ev_txdone = 1'b0;
        ev_rx_end_of_transfer_irq = 1'b0;
        ev_ovf = 1'b0;
        case (state_ff)
            LMB_IDLE: begin
                if (rx_valid && rx_ready) begin
                    // first received byte lands at entry zero
                    mem_we = 1'b1;
                    mem_waddr = '0;
                    nxt_len = `LMB_PTR_W'(1);
                    nxt_ptr = `LMB_PTR_W'(1);
                    if (rx_in.last) begin
                        nxt_ptr = '0;
                        nxt_pending = 1'b1;
                        ev_rx_end_of_transfer_irq = 1'b1;
                    end else begin
                        nxt_state = LMB_RX_FILL;
                    end
                end else if (ctl_wr && pwdata[`LMB_CTRL_SEND] && holds_tx_ff && (len_ff != '0)) begin
                    // hand the written message to the transmitter
                    nxt_state = LMB_TX_SEND;
                    nxt_tx_idx = '0;
                    nxt_ptr = '0;
                end else if (ctl_wr && pwdata[`LMB_CTRL_RESTART]) begin
                    nxt_ptr = '0;
                end else if (port_wr && !pending_ff) begin
                    if (ptr_ff < DEPTH) begin
                        mem_we = 1'b1;
                        mem_wdata = pwdata[7:0];
                        nxt_ptr = ptr_ff + `LMB_PTR_W'(1);
                        nxt_len = ptr_ff + `LMB_PTR_W'(1);
                        nxt_holds_tx = 1'b1;
                    end else begin
                        ev_ovf = 1'b1;
                    end
                end else if (port_rd && pending_ff && !holds_tx_ff && (ptr_ff < len_ff)) begin
                    nxt_ptr = ptr_ff + `LMB_PTR_W'(1);
                    if (ptr_ff + `LMB_PTR_W'(1) == len_ff) begin
                        nxt_pending = 1'b0;
                    end
                end
            end
            LMB_TX_SEND: begin
                if (tx_ready) begin
                    if (tx_last) begin
                        nxt_state = LMB_IDLE;
                        nxt_holds_tx = 1'b0;
                        nxt_len = '0;
                        ev_txdone = 1'b1;
                    end else begin
                        nxt_tx_idx = tx_idx_ff + `LMB_PTR_W'(1);
                    end
                end
            end
            LMB_RX_FILL: begin
                if (rx_valid) begin
                    if (ptr_ff < DEPTH) begin
                        mem_we = 1'b1;
                        nxt_ptr = ptr_ff + `LMB_PTR_W'(1);
                        nxt_len = len_ff + `LMB_PTR_W'(1);
                    end else begin
                        ev_ovf = 1'b1;
                    end
                    if (rx_in.last) begin
                        nxt_state = LMB_IDLE;
                        nxt_ptr = '0;
                        nxt_pending = 1'b1;
                        ev_rx_end_of_transfer_irq = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = LMB_IDLE;
            end
        endcase
    end

    // ownership registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= LMB_IDLE;
            ptr_ff <= '0;
            len_ff <= '0;
            tx_idx_ff <= '0;
            holds_tx_ff <= 1'b0;
            pending_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ptr_ff <= nxt_ptr;
            len_ff <= nxt_len;
            tx_idx_ff <= nxt_tx_idx;
            holds_tx_ff <= nxt_holds_tx;
            pending_ff <= nxt_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, new events win
    always_comb begin
        nxt_istat = istat_ff;
        nxt_imask = imask_ff;
        if (wr && (sel == LMB_SEL_ISTAT)) begin
            nxt_istat = istat_ff & ~pwdata[`LMB_IRQ_W-1:0];
        end
        if (wr && (sel == LMB_SEL_IMASK)) begin
            nxt_imask = pwdata[`LMB_IRQ_W-1:0];
        end
        nxt_istat[`LMB_IRQ_TXDONE] = nxt_istat[`LMB_IRQ_TXDONE] | ev_txdone;
        nxt_istat[`LMB_IRQ_RX_END_OF_TRANSFER_IRQ] = nxt_istat[`LMB_IRQ_RX_END_OF_TRANSFER_IRQ] | ev_rx_end_of_transfer_irq;
        nxt_istat[`LMB_IRQ_OVF] = nxt_istat[`LMB_IRQ_OVF] | ev_ovf;
    end

    // interrupt registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            istat_ff <= '0;
            imask_ff <= `LMB_RST_IMASK;
        end else begin
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux, sent message bytes never come back
    always_comb begin
        prdata = 32'h0000_0000;
        case (sel)
            LMB_SEL_PORT: begin
                if ((state_ff == LMB_IDLE) && !holds_tx_ff && (ptr_ff < len_ff)) begin
                    prdata[7:0] = port_byte;
                end
            end
            LMB_SEL_STAT: begin
                prdata[`LMB_STAT_TXFREE] = tx_buffer_free_flag;
                prdata[`LMB_STAT_RXPTR] = rx_buffer_pointer_flag;
                prdata[`LMB_STAT_PTR_LSB +: `LMB_PTR_W] = ptr_ff;
                prdata[`LMB_STAT_LEN_LSB +: `LMB_PTR_W] = len_ff;
            end
            LMB_SEL_ISTAT: begin
                prdata[`LMB_IRQ_W-1:0] = istat_ff;
            end
            LMB_SEL_IMASK: begin
                prdata[`LMB_IRQ_W-1:0] = imask_ff;
            end
            default: begin
                prdata = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_ptr_step;
        @(posedge clk) disable iff (rst)
        (port_wr && (state_ff == LMB_IDLE) && !pending_ff && !(rx_valid && rx_ready) && (ptr_ff < DEPTH))
        |=> (ptr_ff == $past(ptr_ff) + `LMB_PTR_W'(1));
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step on port write");

    property p_ptr_bound;
        @(posedge clk) disable iff (rst)
        (ptr_ff <= DEPTH) && (len_ff <= DEPTH);
    endproperty
    a_ptr_bound: assert property (p_ptr_bound) else $error("pointer or length beyond store");

    property p_tx_hidden;
        @(posedge clk) disable iff (rst)
        (port_rd && holds_tx_ff) |-> (prdata == 32'h0000_0000);
    endproperty
    a_tx_hidden: assert property (p_tx_hidden) else $error("transmit data read back");

    sequence s_tx_mid;
        tx_valid && tx_ready && !tx_last;
    endsequence
    sequence s_tx_end;
        tx_valid && tx_ready && tx_last;
    endsequence
    property p_tx_mid;
        @(posedge clk) disable iff (rst)
        s_tx_mid |=> tx_valid && (tx_idx_ff == $past(tx_idx_ff) + `LMB_PTR_W'(1));
    endproperty
    a_tx_mid: assert property (p_tx_mid) else $error("transmit byte index did not advance");

    property p_tx_end;
        @(posedge clk) disable iff (rst)
        s_tx_end |=> !tx_valid ##0 istat_ff[`LMB_IRQ_TXDONE] ##0 !holds_tx_ff;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("transmit did not finish cleanly");

    property p_tx_first;
        @(posedge clk) disable iff (rst)
        $rose(tx_valid) |-> (tx_idx_ff == '0);
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("transmit did not start at first byte");

    property p_rx_rewind;
        @(posedge clk) disable iff (rst)
        (rx_valid && rx_ready && rx_in.last) |=> (ptr_ff == '0) && rx_buffer_pointer_flag;
    endproperty
    a_rx_rewind: assert property (p_rx_rewind) else $error("receive end did not rewind pointer");

    property p_rx_read;
        @(posedge clk) disable iff (rst)
        (port_rd && pending_ff && !holds_tx_ff && (state_ff == LMB_IDLE) && !ctl_wr && (ptr_ff < len_ff))
        |-> (prdata[7:0] == port_byte) ##1 (ptr_ff == $past(ptr_ff) + `LMB_PTR_W'(1));
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("receive read did not advance");

endmodule : lmb_msg_buffer

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "lmb_cfg.svh"

module tb
    import lmb_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, tx_ready, rx_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, tx_last, tx_valid, rx_ready, irq;
    logic [7:0] tx_data;
    lmb_byte_t rx_in;
    logic tx_buffer_free_flag, rx_buffer_pointer_flag, rx_end_of_transfer_irq;
    int err_count = 0;
    int n_compared = 0;

    // device under test
    lmb_msg_buffer i_lmb_msg_buffer (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_in(rx_in), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_buffer_free_flag(tx_buffer_free_flag),
        .rx_buffer_pointer_flag(rx_buffer_pointer_flag),
        .rx_end_of_transfer_irq(rx_end_of_transfer_irq), .irq(irq)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // a wait that used up its bound ends the run
    task automatic hang;
        chk("wait_bound", 32'h1, 32'h0);
        end_of_test();
    endtask : hang

    // one apb transfer, answer taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // received message of n bytes, each byte held until rx_ready is seen at a rising edge
    task automatic rx_msg(input int n, input logic [7:0] base);
        int k, j;
        @(posedge clk);
        for (k = 0; k < n; k++) begin
            rx_valid <= 1'b1;
            rx_in.data <= 8'(base + k);
            rx_in.last <= (k == n - 1);
            for (j = 0; j < 16; j++) begin
                @(posedge clk);
                if (rx_ready === 1'b1) break;
            end
            if (j == 16) hang();
        end
        rx_valid <= 1'b0;
    endtask : rx_msg

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd & m);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios

    // reset values and an unmapped address
    task automatic t_reset;
        @(negedge clk);
        chk("tx_valid", 32'h0, tx_valid);
        chk("irq", 32'h0, irq);
        chk("rx_ready", 32'h1, rx_ready);
        chk("tx_free", 32'h1, tx_buffer_free_flag);
        rdchk(`LMB_OFS_STAT, 32'hFFFFFFFF, 32'h1, "stat");
        rdchk(`LMB_OFS_IMASK, 32'hFFFFFFFF, 32'h0, "imask");
        rdchk(`LMB_OFS_ISTAT, 32'hFFFFFFFF, 32'h0, "istat");
        rdchk(`LMB_OFS_PORT, 32'hFFFFFFFF, 32'h0, "port");
        apb(1'b0, 12'h7FC, 32'h0);
        chk("pslverr", 32'h1, er);
        chk("unmapped", 32'h0, rd);
    endtask : t_reset

    // full 96 byte message, overflow, rewind, no readback, send with stall
    task automatic t_tx;
        int k;
        rdchk(`LMB_OFS_STAT, 32'h00000003, 32'h00000001, "free_before_write");
        for (k = 0; k < 96; k++) apb(1'b1, `LMB_OFS_PORT, {24'h0, 8'(k * 7 + 1)});
        rdchk(`LMB_OFS_STAT, 32'h007F7F00, 32'h00606000, "len_ptr");
        apb(1'b1, `LMB_OFS_PORT, 32'h55);
        rdchk(`LMB_OFS_ISTAT, 32'h7, 32'h4, "ovf");
        @(negedge clk);
        chk("irq_masked", 32'h0, irq);
        apb(1'b1, `LMB_OFS_CTRL, 32'h1);
        rdchk(`LMB_OFS_STAT, 32'h007F7F00, 32'h00600000, "rewind");
        rdchk(`LMB_OFS_PORT, 32'hFF, 32'h0, "tx_readback");
        apb(1'b1, `LMB_OFS_IMASK, 32'h1);
        apb(1'b1, `LMB_OFS_CTRL, 32'h2);
        repeat (3) @(negedge clk);
        chk("stall_valid", 32'h1, tx_valid);
        chk("stall_data", 32'h1, tx_data);
        @(posedge clk);
        tx_ready <= 1'b1;
        for (k = 0; k < 96; k++) begin
            @(negedge clk);
            chk("tx_valid", 32'h1, tx_valid);
            chk("tx_data", {24'h0, 8'(k * 7 + 1)}, tx_data);
            chk("tx_last", {31'h0, k == 95}, tx_last);
            @(posedge clk);
        end
        tx_ready <= 1'b0;
        @(negedge clk);
        chk("tx_end", 32'h0, tx_valid);
        chk("irq_txdone", 32'h1, irq);
        apb(1'b1, `LMB_OFS_ISTAT, 32'h5);
        @(negedge clk);
        chk("irq_clear", 32'h0, irq);
        rdchk(`LMB_OFS_PORT, 32'hFF, 32'h0, "sent_readback");
    endtask : t_tx

    // received message of five bytes read out through the port
    task automatic t_rx;
        int k;
        apb(1'b1, `LMB_OFS_IMASK, 32'h2);
        rx_msg(5, 8'hC0);
        @(negedge clk);
        chk("rx_ptr_flag", 32'h1, rx_buffer_pointer_flag);
        chk("rx_eot", 32'h1, rx_end_of_transfer_irq);
        chk("rx_ready_busy", 32'h0, rx_ready);
        chk("irq_rx", 32'h1, irq);
        chk("tx_free_busy", 32'h0, tx_buffer_free_flag);
        rdchk(`LMB_OFS_STAT, 32'h007F7F03, 32'h00050002, "rx_stat");
        for (k = 0; k < 5; k++) rdchk(`LMB_OFS_PORT, 32'hFF, 32'(8'hC0 + k), "rx_byte");
        @(negedge clk);
        chk("rx_ptr_done", 32'h0, rx_buffer_pointer_flag);
        chk("rx_ready_back", 32'h1, rx_ready);
        apb(1'b1, `LMB_OFS_ISTAT, 32'h2);
        @(negedge clk);
        chk("irq_rx_clear", 32'h0, irq);
        chk("rx_eot_clear", 32'h0, rx_end_of_transfer_irq);
    endtask : t_rx

    // received message longer than the store: excess bytes dropped, overflow flagged
    task automatic t_rx_ovf;
        int k;
        rx_msg(98, 8'h00);
        @(negedge clk);
        chk("ovf_ptr_flag", 32'h1, rx_buffer_pointer_flag);
        rdchk(`LMB_OFS_ISTAT, 32'h7, 32'h6, "rx_ovf");
        rdchk(`LMB_OFS_STAT, 32'h007F7F03, 32'h00600002, "ovf_stat");
        for (k = 0; k < 96; k++) rdchk(`LMB_OFS_PORT, 32'hFF, 32'(k), "ovf_byte");
        @(negedge clk);
        chk("ovf_ptr_done", 32'h0, rx_buffer_pointer_flag);
        apb(1'b1, `LMB_OFS_ISTAT, 32'h6);
        rdchk(`LMB_OFS_ISTAT, 32'h7, 32'h0, "ovf_clear");
    endtask : t_rx_ovf

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_in = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_rx_ovf();
        end_of_test();
    end
endmodule : tb

`default_nettype wire
